// file: hdl/gtu_pkg.sv
// constants, field positions and mode codes of the general timer unit
// Summary of operation
// - Two 16-bit halves run independently or join as one 32-bit timer or clock.
// - Reset: inactive, controls cleared, counters and loads 0xFFFF, prescales 0x00.
// - Config value 0 selects 32-bit timer, value 1 selects 32-bit clock.
// - 32-bit load write fills low load from bits 15:0, high from upper half.
// - 32-bit read of low count gives high half above low half.
// - 32-bit timer takes one-shot or periodic from low mode field only.
// - Setting low enable starts the joined counter down from its preload.
// - At zero the joined counter reloads the joined load on next cycle.
// - One-shot stops and clears low enable after reload; periodic keeps counting.
// - Zero sets low timeout raw flag, held until software clears it.
// - Unmasked timeout also sets the masked timeout flag.
// - With trigger enable, one-clock output pulse while counter sits at zero.
// - Load rewrite while counting is taken next cycle, counting continues.
// - Low stall bit freezes the counter while stall request stays high.
// - Clock mode counts up, loaded with 0x00000001 when first selected.
// - Clock mode advances on the dedicated slow clock pin only.
// - On count equal match, clock rolls to zero and keeps counting.
// - Clock match sets raw flag, and masked flag plus interrupt if unmasked.
// - Writing the clock clear bit clears both clock match flags.
// - Stall override bit makes either stall bit ineffective.
// - 32-bit modes act as one timer; 16-bit mode halves are independent.
// - Odd capture pin serves 16-bit mode, even capture pin 32-bit mode.
// - Config value 0x4 selects split 16-bit operation.
package gtu_pkg;
   typedef enum logic [2:0] {
      GTU_CFG_32_TIMER = 3'h0,
      GTU_CFG_32_CLOCK = 3'h1,
      GTU_CFG_16_SPLIT = 3'h4
   } gtu_cfg_t;

   localparam logic [2:0]  GTU_CFG_RESET      = 3'h0;
   localparam logic [15:0] GTU_HALF_RESET     = 16'hFFFF;
   localparam logic [7:0]  GTU_PRESCALE_RESET = 8'h00;
   localparam logic [31:0] GTU_CLOCK_FIRST    = 32'h0000_0001;
   localparam logic [31:0] GTU_MATCH_RESET    = 32'hFFFF_FFFF;

   // low and high mode field codes
   localparam logic [1:0]  GTU_MODE_ONE_SHOT  = 2'h1;
   localparam logic [1:0]  GTU_MODE_PERIODIC  = 2'h2;

   // control word bit positions
   localparam int          GTU_CTL_LOW_EN     = 0;
   localparam int          GTU_CTL_LOW_STALL  = 1;
   localparam int          GTU_CTL_CLK_OVR    = 4;
   localparam int          GTU_CTL_LOW_TRIG   = 5;
   localparam int          GTU_CTL_HIGH_EN    = 8;
   localparam int          GTU_CTL_HIGH_STALL = 9;
   localparam logic [15:0] GTU_CTL_MASK       = 16'h0333;
   localparam logic [15:0] GTU_CTL_RESET      = 16'h0000;

   // interrupt flag positions
   localparam int          GTU_FLAG_W         = 4;
   localparam int          GTU_FLAG_LOW_TO    = 0;
   localparam int          GTU_FLAG_HIGH_TO   = 1;
   localparam int          GTU_FLAG_CLOCK     = 3;
   localparam logic [3:0]  GTU_FLAG_RESET     = 4'h0;
endpackage

// file: hdl/gtu_half_if.sv
// signals between the timer control and one 16-bit half counter
`timescale 1ns/1ps
interface gtu_half_if;
   logic        load;
   logic [15:0] load_val;
   logic        step;
   logic        up;
   logic [15:0] count;
   logic        at_zero;
   logic        at_max;
   modport ctrl (output load, load_val, step, up, input count, at_zero, at_max);
   modport cnt  (input load, load_val, step, up, output count, at_zero, at_max);
endinterface

// file: hdl/gtu_half_counter.sv
// one 16-bit up/down half counter with load
`timescale 1ns/1ps
module gtu_half_counter (
   input wire logic clock,
   input wire logic resetn,
   gtu_half_if.cnt  hif
);
   // load beats stepping so a rewrite is never lost
   always_ff @(posedge clock) begin
      if (!resetn) begin
         hif.count <= gtu_pkg::GTU_HALF_RESET;
      end else if (hif.load) begin
         hif.count <= hif.load_val;
      end else if (hif.step) begin
         hif.count <= hif.up ? hif.count + 16'h0001 : hif.count - 16'h0001;
      end
   end

   // carry and borrow taps for joining halves
   assign hif.at_zero = (hif.count == 16'h0000);
   assign hif.at_max  = (hif.count == 16'hFFFF);
endmodule // gtu_half_counter

// file: hdl/gtu_slow_sync.sv
// slow clock pin synchroniser with rising edge tick
`timescale 1ns/1ps
module gtu_slow_sync (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic pin,
   output logic      tick
);
   logic s1;
   logic s2;
   logic s3;

   // first stage feeds only the second, edge taken after
   always_ff @(posedge clock) begin
      if (!resetn) begin
         s1   <= 1'b0;
         s2   <= 1'b0;
         s3   <= 1'b0;
         tick <= 1'b0;
      end else begin
         s1   <= pin;
         s2   <= s1;
         s3   <= s2;
         tick <= s2 & ~s3;
      end
   end
endmodule // gtu_slow_sync

// file: hdl/gtu_top.sv
// general timer unit: two halves, 32-bit timer, 32-bit clock, split mode
`timescale 1ns/1ps
module gtu_top (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        cfg_wr,
   input  wire logic [2:0]  cfg_wdata,
   input  wire logic [1:0]  low_mode_field,
   input  wire logic [1:0]  high_mode_field,
   input  wire logic        ctl_wr,
   input  wire logic [15:0] ctl_wdata,
   input  wire logic        low_load_wr,
   input  wire logic [31:0] low_load_wdata,
   input  wire logic        high_load_wr,
   input  wire logic [15:0] high_load_wdata,
   input  wire logic        low_prescale_wr,
   input  wire logic        high_prescale_wr,
   input  wire logic [7:0]  prescale_wdata,
   input  wire logic        match_wr,
   input  wire logic [31:0] match_wdata,
   input  wire logic [3:0]  irq_mask_reg,
   input  wire logic        irq_clear_wr,
   input  wire logic [3:0]  irq_clear_reg,
   input  wire logic        stall_req,
   input  wire logic        slow_clock_pin,
   input  wire logic [1:0]  capture_compare_pin,
   output logic [2:0]       timer_config_reg,
   output logic [15:0]      timer_control_reg,
   output logic [31:0]      low_count_value,
   output logic [15:0]      high_count_value,
   output logic [15:0]      low_interval_load,
   output logic [15:0]      high_interval_load,
   output logic [7:0]       low_prescale_reg,
   output logic [7:0]       high_prescale_reg,
   output logic [31:0]      low_match_reg,
   output logic [3:0]       raw_irq_status,
   output logic [3:0]       masked_irq_status,
   output logic             timer_irq,
   output logic             trigger_out,
   output logic             capture_level
);
   gtu_half_if lo_if ();
   gtu_half_if hi_if ();
   logic        slow_tick, clock_seen, is_32t, is_clk, is_16;
   logic        stall_lo, stall_hi, stall_any, run32, zero32, first_clock;
   logic        hit_lo, hit_hi, hit_clock, arrive_lo, clr_en_lo, clr_en_hi;
   logic [31:0] cnt32;
   logic [3:0]  clr_mask;
   logic [3:0]  next_raw;

   gtu_half_counter u_low (
      .clock  (clock),
      .resetn (resetn),
      .hif    (lo_if)
   );
   gtu_half_counter u_high (
      .clock  (clock),
      .resetn (resetn),
      .hif    (hi_if)
   );
   // slow pin is the only time base of clock mode
   gtu_slow_sync u_slow (
      .clock  (clock),
      .resetn (resetn),
      .pin    (slow_clock_pin),
      .tick   (slow_tick)
   );

   // mode decode and stall qualification
   assign is_32t    = (timer_config_reg == gtu_pkg::GTU_CFG_32_TIMER);
   assign is_clk    = (timer_config_reg == gtu_pkg::GTU_CFG_32_CLOCK);
   assign is_16     = (timer_config_reg == gtu_pkg::GTU_CFG_16_SPLIT);
   assign stall_lo  = stall_req & timer_control_reg[gtu_pkg::GTU_CTL_LOW_STALL]
                      & ~timer_control_reg[gtu_pkg::GTU_CTL_CLK_OVR];
   assign stall_hi  = stall_req & timer_control_reg[gtu_pkg::GTU_CTL_HIGH_STALL]
                      & ~timer_control_reg[gtu_pkg::GTU_CTL_CLK_OVR];
   assign stall_any = stall_lo | stall_hi;
   assign cnt32     = {hi_if.count, lo_if.count};
   assign zero32    = lo_if.at_zero & hi_if.at_zero;
   assign run32     = is_32t & timer_control_reg[gtu_pkg::GTU_CTL_LOW_EN] & ~stall_lo;
   assign first_clock = cfg_wr & (cfg_wdata == gtu_pkg::GTU_CFG_32_CLOCK) & ~clock_seen;

   // counter steering per mode; first clock selection overrides all
   always_comb begin
      lo_if.load     = 1'b0;
      lo_if.load_val = gtu_pkg::GTU_HALF_RESET;
      lo_if.step     = 1'b0;
      lo_if.up       = 1'b0;
      hi_if.load     = 1'b0;
      hi_if.load_val = gtu_pkg::GTU_HALF_RESET;
      hi_if.step     = 1'b0;
      hi_if.up       = 1'b0;
      hit_lo         = 1'b0;
      hit_hi         = 1'b0;
      hit_clock      = 1'b0;
      arrive_lo      = 1'b0;
      clr_en_lo      = 1'b0;
      clr_en_hi      = 1'b0;
      if (first_clock) begin
         lo_if.load     = 1'b1;
         hi_if.load     = 1'b1;
         lo_if.load_val = gtu_pkg::GTU_CLOCK_FIRST[15:0];
         hi_if.load_val = gtu_pkg::GTU_CLOCK_FIRST[31:16];
      end else begin
         unique case (timer_config_reg)
            gtu_pkg::GTU_CFG_32_TIMER: begin
               if (low_load_wr) begin
                  lo_if.load     = 1'b1;
                  hi_if.load     = 1'b1;
                  lo_if.load_val = low_load_wdata[15:0];
                  hi_if.load_val = low_load_wdata[31:16];
               end else if (run32 && zero32) begin
                  lo_if.load     = 1'b1;
                  hi_if.load     = 1'b1;
                  lo_if.load_val = low_interval_load;
                  hi_if.load_val = high_interval_load;
                  hit_lo         = 1'b1;
                  clr_en_lo      = (low_mode_field == gtu_pkg::GTU_MODE_ONE_SHOT);
               end else if (run32) begin
                  lo_if.step = 1'b1;
                  hi_if.step = lo_if.at_zero;
                  arrive_lo  = (cnt32 == 32'h0000_0001);
               end
            end
            gtu_pkg::GTU_CFG_32_CLOCK: begin
               if (slow_tick && timer_control_reg[gtu_pkg::GTU_CTL_LOW_EN]
                   && !stall_any) begin
                  if (cnt32 == low_match_reg) begin
                     lo_if.load     = 1'b1;
                     hi_if.load     = 1'b1;
                     lo_if.load_val = 16'h0000;
                     hi_if.load_val = 16'h0000;
                     hit_clock      = 1'b1;
                  end else begin
                     lo_if.step = 1'b1;
                     lo_if.up   = 1'b1;
                     hi_if.step = lo_if.at_max;
                     hi_if.up   = 1'b1;
                  end
               end
            end
            gtu_pkg::GTU_CFG_16_SPLIT: begin
               // each half keeps its own enable, mode and load
               if (low_load_wr) begin
                  lo_if.load     = 1'b1;
                  lo_if.load_val = low_load_wdata[15:0];
               end else if (timer_control_reg[gtu_pkg::GTU_CTL_LOW_EN] && !stall_lo) begin
                  if (lo_if.at_zero) begin
                     lo_if.load     = 1'b1;
                     lo_if.load_val = low_interval_load;
                     hit_lo         = 1'b1;
                     clr_en_lo      = (low_mode_field == gtu_pkg::GTU_MODE_ONE_SHOT);
                  end else begin
                     lo_if.step = 1'b1;
                     arrive_lo  = (lo_if.count == 16'h0001);
                  end
               end
               if (high_load_wr) begin
                  hi_if.load     = 1'b1;
                  hi_if.load_val = high_load_wdata;
               end else if (timer_control_reg[gtu_pkg::GTU_CTL_HIGH_EN] && !stall_hi) begin
                  if (hi_if.at_zero) begin
                     hi_if.load     = 1'b1;
                     hi_if.load_val = high_interval_load;
                     hit_hi         = 1'b1;
                     clr_en_hi      = (high_mode_field == gtu_pkg::GTU_MODE_ONE_SHOT);
                  end else begin
                     hi_if.step = 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // configuration: illegal codes are dropped so the decode stays total
   always_ff @(posedge clock) begin
      if (!resetn) begin
         timer_config_reg <= gtu_pkg::GTU_CFG_RESET;
         clock_seen       <= 1'b0;
      end else if (cfg_wr && (cfg_wdata == gtu_pkg::GTU_CFG_32_TIMER
                   || cfg_wdata == gtu_pkg::GTU_CFG_32_CLOCK
                   || cfg_wdata == gtu_pkg::GTU_CFG_16_SPLIT)) begin
         timer_config_reg <= cfg_wdata;
         clock_seen       <= clock_seen | (cfg_wdata == gtu_pkg::GTU_CFG_32_CLOCK);
      end
   end

   // control word; a software write outranks the hardware enable clear
   always_ff @(posedge clock) begin
      if (!resetn) begin
         timer_control_reg <= gtu_pkg::GTU_CTL_RESET;
      end else if (ctl_wr) begin
         timer_control_reg <= ctl_wdata & gtu_pkg::GTU_CTL_MASK;
      end else begin
         if (clr_en_lo) begin
            timer_control_reg[gtu_pkg::GTU_CTL_LOW_EN] <= 1'b0;
         end
         if (clr_en_hi) begin
            timer_control_reg[gtu_pkg::GTU_CTL_HIGH_EN] <= 1'b0;
         end
      end
   end

   // interval loads; the 32-bit write spans both halves
   always_ff @(posedge clock) begin
      if (!resetn) begin
         low_interval_load  <= gtu_pkg::GTU_HALF_RESET;
         high_interval_load <= gtu_pkg::GTU_HALF_RESET;
      end else begin
         if (low_load_wr) begin
            low_interval_load <= low_load_wdata[15:0];
         end
         if (low_load_wr && !is_16) begin
            high_interval_load <= low_load_wdata[31:16];
         end else if (high_load_wr) begin
            high_interval_load <= high_load_wdata;
         end
      end
   end

   // prescales are held for read back only, no mode counts with them; match for clock mode
   always_ff @(posedge clock) begin
      if (!resetn) begin
         low_prescale_reg  <= gtu_pkg::GTU_PRESCALE_RESET;
         high_prescale_reg <= gtu_pkg::GTU_PRESCALE_RESET;
         low_match_reg     <= gtu_pkg::GTU_MATCH_RESET;
      end else begin
         if (low_prescale_wr) begin
            low_prescale_reg <= prescale_wdata;
         end
         if (high_prescale_wr) begin
            high_prescale_reg <= prescale_wdata;
         end
         if (match_wr) begin
            low_match_reg <= match_wdata;
         end
      end
   end

   // flags: a set in the clearing cycle wins
   assign clr_mask = irq_clear_wr ? irq_clear_reg : 4'h0;
   always_comb begin
      next_raw = raw_irq_status & ~clr_mask;
      next_raw[gtu_pkg::GTU_FLAG_LOW_TO]  = next_raw[gtu_pkg::GTU_FLAG_LOW_TO] | hit_lo;
      next_raw[gtu_pkg::GTU_FLAG_HIGH_TO] = next_raw[gtu_pkg::GTU_FLAG_HIGH_TO] | hit_hi;
      next_raw[gtu_pkg::GTU_FLAG_CLOCK]   = next_raw[gtu_pkg::GTU_FLAG_CLOCK] | hit_clock;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         raw_irq_status    <= gtu_pkg::GTU_FLAG_RESET;
         masked_irq_status <= gtu_pkg::GTU_FLAG_RESET;
         timer_irq         <= 1'b0;
      end else begin
         raw_irq_status    <= next_raw;
         masked_irq_status <= next_raw & irq_mask_reg;
         timer_irq         <= |(next_raw & irq_mask_reg);
      end
   end

   // trigger rises with the edge that brings the count to zero
   always_ff @(posedge clock) begin
      if (!resetn) begin
         trigger_out <= 1'b0;
      end else begin
         trigger_out <= timer_control_reg[gtu_pkg::GTU_CTL_LOW_TRIG] & arrive_lo;
      end
   end

   // read views, registered, so they trail the counters by one cycle
   always_ff @(posedge clock) begin
      if (!resetn) begin
         low_count_value  <= {16'h0000, gtu_pkg::GTU_HALF_RESET};
         high_count_value <= gtu_pkg::GTU_HALF_RESET;
         capture_level    <= 1'b0;
      end else begin
         low_count_value  <= is_16 ? {16'h0000, lo_if.count} : cnt32;
         high_count_value <= hi_if.count;
         capture_level    <= is_16 ? capture_compare_pin[1] : capture_compare_pin[0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   AST_RESET_STATE: assert property (@(posedge clock) disable iff (1'b0)
      !resetn |=> (cnt32 == 32'hFFFF_FFFF && low_interval_load == 16'hFFFF
                  && high_interval_load == 16'hFFFF && low_prescale_reg == 8'h00
                  && timer_control_reg == 16'h0000))
      else $error("reset state wrong");
   AST_CFG_CLOCK: assert property (cfg_wr && cfg_wdata == 3'h1 |=> is_clk)
      else $error("clock mode not selected");
   AST_CFG_SPLIT: assert property (cfg_wr && cfg_wdata == 3'h4 |=> is_16)
      else $error("split mode not selected");
   AST_LOAD_SPLIT: assert property (is_32t && low_load_wr && !first_clock |=>
      cnt32 == $past(low_load_wdata) && {high_interval_load, low_interval_load}
      == $past(low_load_wdata))
      else $error("32-bit load not split");
   AST_READ_JOIN: assert property (!is_16 |=> low_count_value == $past(cnt32))
      else $error("joined read wrong");
   AST_RELOAD: assert property (hit_lo && is_32t |=>
      cnt32 == $past({high_interval_load, low_interval_load}))
      else $error("no reload after zero");
   AST_ONE_SHOT: assert property (hit_lo && is_32t && low_mode_field == 2'h1 && !ctl_wr
      |=> !timer_control_reg[0]
      ##1 ($past(low_load_wr) || $past(cfg_wr) || cnt32 == $past(cnt32)))
      else $error("one shot kept running");
   AST_PERIODIC: assert property (hit_lo && is_32t && low_mode_field == 2'h2 && !ctl_wr
      |=> timer_control_reg[0])
      else $error("periodic enable dropped");
   AST_FLAG_SET: assert property (hit_lo |=> raw_irq_status[0])
      else $error("timeout flag not set");
   AST_FLAG_HOLD: assert property (raw_irq_status[0] && !(irq_clear_wr && irq_clear_reg[0])
      |=> raw_irq_status[0])
      else $error("timeout flag lost");
   AST_MASKED: assert property (raw_irq_status[0] && $past(irq_mask_reg[0])
      |-> masked_irq_status[0] && timer_irq)
      else $error("masked flag missing");
   AST_TRIG_PULSE: assert property (trigger_out |-> cnt32[15:0] == 16'h0000
      ##1 !trigger_out)
      else $error("trigger not one cycle at zero");
   AST_STALL: assert property (is_32t && stall_lo && !low_load_wr && !cfg_wr
      |=> cnt32 == $past(cnt32))
      else $error("stall did not freeze");
   AST_CLOCK_FIRST: assert property (first_clock |=> cnt32 == 32'h0000_0001)
      else $error("clock first load wrong");
   AST_CLOCK_ROLL: assert property (hit_clock |=> cnt32 == 32'h0000_0000
      && raw_irq_status[3])
      else $error("clock match roll wrong");
   AST_CLOCK_CLEAR: assert property (irq_clear_wr && irq_clear_reg[3] && !hit_clock
      |=> !raw_irq_status[3] && !masked_irq_status[3])
      else $error("clock flags not cleared");
   COV_ONE_SHOT: cover property (hit_lo && is_32t && low_mode_field == 2'h1);
   COV_PERIODIC_TWICE: cover property (hit_lo && is_32t ##[1:40] hit_lo);
   COV_CLOCK_MATCH: cover property (hit_clock);
   COV_STALL: cover property (run32 ##1 stall_lo [*3]);
endmodule // gtu_top

// file: test/gtu_tb.sv
// self-checking bench for the general timer unit
`timescale 1ns/1ps
module tb;
   logic        clock = 1'b0, resetn = 1'b0, cfg_wr = 1'b0, ctl_wr = 1'b0;
   logic        low_load_wr = 1'b0, high_load_wr = 1'b0, match_wr = 1'b0;
   logic        low_prescale_wr = 1'b0, high_prescale_wr = 1'b0, irq_clear_wr = 1'b0;
   logic        stall_req = 1'b0, slow_clock_pin = 1'b0, timer_irq, trigger_out, capture_level;
   logic [1:0]  low_mode_field = '0, high_mode_field = '0, capture_compare_pin = '0;
   logic [2:0]  cfg_wdata = '0, timer_config_reg;
   logic [3:0]  irq_mask_reg = '0, irq_clear_reg = '0, raw_irq_status, masked_irq_status;
   logic [7:0]  prescale_wdata = '0, low_prescale_reg, high_prescale_reg;
   logic [15:0] ctl_wdata = '0, high_load_wdata = '0, timer_control_reg, high_count_value;
   logic [15:0] low_interval_load, high_interval_load;
   logic [31:0] low_load_wdata = '0, match_wdata = '0, low_count_value, low_match_reg, v;
   int          n_fail = 0, n_tests = 0, n;

   gtu_top dut (.clock, .resetn, .cfg_wr, .cfg_wdata, .low_mode_field, .high_mode_field,
      .ctl_wr, .ctl_wdata, .low_load_wr, .low_load_wdata, .high_load_wr, .high_load_wdata,
      .low_prescale_wr, .high_prescale_wr, .prescale_wdata, .match_wr, .match_wdata,
      .irq_mask_reg, .irq_clear_wr, .irq_clear_reg, .stall_req, .slow_clock_pin,
      .capture_compare_pin, .timer_config_reg, .timer_control_reg, .low_count_value,
      .high_count_value, .low_interval_load, .high_interval_load, .low_prescale_reg,
      .high_prescale_reg, .low_match_reg, .raw_irq_status, .masked_irq_status, .timer_irq,
      .trigger_out, .capture_level);

   // 200 MHz system clock
   always #2.5 clock = ~clock;

   // inputs move 1 ns after the edge so the design never races the bench
   task automatic tick(int k);
      repeat (k) @(posedge clock);
      #1;
   endtask

   // one-cycle write strobe
   task automatic strobe(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // bounded wait, a timer that never fires falls through to the next check
   task automatic wait_trig();
      n = 0;
      while (trigger_out !== 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
   endtask

   // one slow clock period, long enough for the three-flop sampler
   task automatic slow_pulse();
      slow_clock_pin = 1'b1;
      tick(6);
      slow_clock_pin = 1'b0;
      tick(6);
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // the whole run needs well under 1000 cycles
   initial begin
      #10000;
      n_fail++;
      complete_run();
   end

   initial begin
      repeat (16) @(posedge clock);
      #1 resetn = 1'b1;
      tick(2);
      chk("config", 32'h0000_0000, timer_config_reg);
      chk("control", 32'h0000_0000, timer_control_reg);
      chk("loads", 32'hffff_ffff, {high_interval_load, low_interval_load});
      chk("prescales", 32'h0000_0000, {high_prescale_reg, low_prescale_reg});
      chk("count", 32'hffff_ffff, low_count_value);
      $display("test reset done");
      // joined load and read, then a borrow across the halves
      low_load_wdata = 32'h0001_0000;
      strobe(low_load_wr);
      chk("load low", 32'h0000_0000, low_interval_load);
      chk("load high", 32'h0000_0001, high_interval_load);
      tick(1);
      chk("joined", 32'h0001_0000, low_count_value);
      low_mode_field = 2'h2;
      ctl_wdata = 16'h0001;
      strobe(ctl_wr);
      // the read view trails the counter by one cycle
      tick(2);
      chk("borrow", 32'h0000_ffff, low_count_value);
      ctl_wdata = 16'h0000;
      strobe(ctl_wr);
      $display("test joined access done");
      // one-shot with trigger, high mode field set the other way
      low_load_wdata = 32'h0000_0002;
      strobe(low_load_wr);
      irq_mask_reg = 4'h1;
      low_mode_field = 2'h1;
      high_mode_field = 2'h2;
      ctl_wdata = 16'h0021;
      strobe(ctl_wr);
      wait_trig();
      chk("trigger", 32'h0000_0001, trigger_out);
      tick(1);
      chk("trigger width", 32'h0000_0000, trigger_out);
      tick(2);
      chk("enable cleared", 32'h0000_0000, timer_control_reg[0]);
      chk("raw", 32'h0000_0001, raw_irq_status);
      chk("masked", 32'h0000_0001, masked_irq_status);
      chk("irq", 32'h0000_0001, timer_irq);
      tick(5);
      chk("reloaded stop", 32'h0000_0002, low_count_value);
      irq_clear_reg = 4'h8;
      strobe(irq_clear_wr);
      chk("other kept", 32'h0000_0001, raw_irq_status);
      // an edge with the strobe low keeps the two clears apart
      tick(1);
      irq_clear_reg = 4'h1;
      strobe(irq_clear_wr);
      tick(2);
      chk("cleared", 32'h0000_0000, {raw_irq_status, masked_irq_status, timer_irq});
      $display("test one-shot done");
      // periodic from the low field only, period of load plus one
      low_mode_field = 2'h2;
      high_mode_field = 2'h1;
      strobe(ctl_wr);
      wait_trig();
      n = 0;
      do begin
         tick(1);
         n++;
      end while (trigger_out !== 1'b1 && n < 50);
      chk("period", 32'h0000_0003, n);
      chk("still on", 32'h0000_0001, timer_control_reg[0]);
      low_load_wdata = 32'h0000_0040;
      strobe(low_load_wr);
      tick(1);
      chk("reload live", 32'h0000_0040, low_count_value);
      stall_req = 1'b1;
      ctl_wdata = 16'h0023;
      strobe(ctl_wr);
      tick(2);
      v = low_count_value;
      tick(4);
      chk("stalled", v, low_count_value);
      ctl_wdata = 16'h0033;
      strobe(ctl_wr);
      tick(3);
      chk("override", 32'h0000_0001, {31'h0, low_count_value !== v});
      stall_req = 1'b0;
      ctl_wdata = 16'h0000;
      strobe(ctl_wr);
      $display("test periodic done");
      // clock mode: starts at one, slow pin only, rolls over on match
      cfg_wdata = 3'h1;
      strobe(cfg_wr);
      tick(1);
      chk("clock cfg", 32'h0000_0001, timer_config_reg);
      chk("clock first", 32'h0000_0001, low_count_value);
      match_wdata = 32'h0000_0003;
      capture_compare_pin = 2'h1;
      strobe(match_wr);
      chk("match", 32'h0000_0003, low_match_reg);
      irq_mask_reg = 4'h8;
      ctl_wdata = 16'h0001;
      strobe(ctl_wr);
      tick(10);
      chk("no slow edge", 32'h0000_0001, low_count_value);
      chk("even pin", 32'h0000_0001, capture_level);
      repeat (3) slow_pulse();
      chk("rollover", 32'h0000_0000, low_count_value);
      // the timeout flag of the periodic run is still held
      chk("clock flags", 32'h0000_0098, {raw_irq_status, masked_irq_status});
      chk("clock irq", 32'h0000_0001, timer_irq);
      stall_req = 1'b1;
      ctl_wdata = 16'h0013;
      strobe(ctl_wr);
      slow_pulse();
      chk("override clock", 32'h0000_0001, low_count_value);
      ctl_wdata = 16'h0003;
      strobe(ctl_wr);
      slow_pulse();
      chk("stall clock", 32'h0000_0001, low_count_value);
      stall_req = 1'b0;
      irq_clear_reg = 4'h8;
      strobe(irq_clear_wr);
      tick(2);
      chk("clock clear", 32'h0000_0010, {raw_irq_status, masked_irq_status});
      $display("test clock done");
      // illegal config ignored, split mode and capture pin choice
      cfg_wdata = 3'h2;
      strobe(cfg_wr);
      chk("bad cfg", 32'h0000_0001, timer_config_reg);
      tick(1);
      cfg_wdata = 3'h4;
      strobe(cfg_wr);
      chk("split cfg", 32'h0000_0004, timer_config_reg);
      capture_compare_pin = 2'h2;
      high_load_wdata = 16'h0007;
      strobe(high_load_wr);
      tick(1);
      chk("high alone", 32'h0000_0007, high_count_value);
      chk("odd pin", 32'h0000_0001, capture_level);
      prescale_wdata = 8'h5a;
      strobe(low_prescale_wr);
      chk("prescale", 32'h0000_005a, low_prescale_reg);
      $display("test split done");
      complete_run();
   end
endmodule // tb
